// *** bench/dhs_host_model.sv ***
module dhs_host_model (
	// clock
	input  wire logic CLOCK,
	// device serial output and packet strobe
	input  wire logic TXD,
	input  wire logic PACKET_STROBE_N,
	// telecommand line
	output logic      RXD
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT_NS = dhs_pkg::BAUD_CYC * 100;  // one bit at 100 ns per cycle
	logic [7:0] rx_q[$];   // characters seen on the serial output
	logic [7:0] b;         // character being decoded
	int         stop_errs; // stop bits seen low
	time        t_fall;    // strobe fall
	time        t_stop;    // end of the last stop bit
	time        lead_ns;   // strobe fall to first start bit
	time        tail_ns;   // last stop bit to strobe rise
	initial begin
		RXD = 1'h1;
		stop_errs = 0;
		t_stop = 0;
	end
	// sample each bit in its middle; a start that is gone by then is dropped
	always @(negedge TXD) begin
		#(BIT_NS / 2);
		if (TXD === 1'h0) begin
			for (int i = 0; i < 8; i++) begin
				#(BIT_NS);
				b[i] = TXD;
			end
			#(BIT_NS);
			if (TXD !== 1'h1)
				stop_errs++;
			rx_q.push_back(b);
			t_stop = $time + BIT_NS / 2;
		end
	end
	// lead time of the strobe
	always @(negedge PACKET_STROBE_N) begin
		t_fall = $time;
		@(negedge TXD);
		lead_ns = $time - t_fall;
	end
	// tail time of the strobe
	always @(posedge PACKET_STROBE_N)
		tail_ns = $time - t_stop;
	// send one character; a low stop bit is cut short so the receiver
	// does not read its remainder as a fresh start bit
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge CLOCK);
			#1;
			RXD = f[i];
			repeat (i == 9 && !stop ? dhs_pkg::HALF_BAUD + 9 : dhs_pkg::BAUD_CYC - 1)
				@(posedge CLOCK);
		end
		@(posedge CLOCK);
		#1;
		RXD = 1'h1;
		repeat (dhs_pkg::BAUD_CYC) @(posedge CLOCK);
		#1;
	endtask
endmodule

// *** bench/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 50;    // short tick: one second is 500 cycles
	localparam int ACPS = 3;  // low alarm threshold, few events needed
	// design inputs
	logic        clock, rst_n, event_level, pkt_valid, pkt_last, rxd;
	logic [7:0]  pkt_data;
	// design outputs
	logic        pkt_ready, slot, slot_meas, txd, strobe_n, cmd_valid, cmd_err;
	logic        error_n, alarm_n, fix_n, en_n, dose_valid;
	logic [7:0]  cmd_data;
	logic [19:0] counts_per_minute;
	// bookkeeping
	int          n_errors, cmp_count, n_ev, now;
	dhs_signals #(.TICK_CYC(T), .ALARM_CPS(ACPS)) i_dhs_signals (
		.CLOCK(clock), .RST_N(rst_n), .EVENT_LEVEL(event_level),
		.PKT_VALID(pkt_valid), .PKT_DATA(pkt_data), .PKT_LAST(pkt_last),
		.PKT_READY(pkt_ready), .SLOT(slot), .SLOT_MEAS(slot_meas), .TXD(txd),
		.RXD(rxd), .PACKET_STROBE_N(strobe_n), .CMD_VALID(cmd_valid),
		.CMD_DATA(cmd_data), .CMD_FRAME_ERR(cmd_err), .ERROR_N(error_n),
		.ALARM_N(alarm_n), .FIXED_COUNT_PULSE_N(fix_n), .ENERGY_COUNT_PULSE_N(en_n),
		.COUNTS_PER_MINUTE(counts_per_minute), .DOSE_VALID(dose_valid));
	dhs_host_model i_dhs_host_model (.CLOCK(clock), .TXD(txd),
		.PACKET_STROBE_N(strobe_n), .RXD(rxd));
	// 10 MHz clock
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	// cycles since reset release, to judge schedule times
	always @(posedge clock or negedge rst_n)
		if (!rst_n)
			now <= 0;
		else
			now <= now + 1;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic rng(input string nm, input int lo, input int hi, input int g);
		cmp_count++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// step n edges, landing just after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// one detector event
	task automatic ev(input int hi);
		event_level = 1'h1;
		n_ev++;
		cyc(hi);
		event_level = 1'h0;
		cyc(20);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// outputs parked while reset is held
	task automatic t_reset;
		rst_n = 1'h0;
		cyc(2);
		chk("strobe_n", 1'h1, strobe_n);
		chk("error_n", 1'h1, error_n);
		chk("alarm_n", 1'h1, alarm_n);
		chk("txd", 1'h1, txd);
		chk("dose_valid", 1'h0, dose_valid);
		chk("cpm", 20'h0, counts_per_minute);
		rst_n = 1'h1;
		$display("test reset done");
	endtask
	// packet slots with the telecommand line left idle
	task automatic t_sched;
		int   c[$];
		logic m[$];
		while (now < 213 * T) begin
			cyc(1);
			if (slot === 1'h1) begin
				c.push_back(now);
				m.push_back(slot_meas);
			end
		end
		chk("slot count", 3, c.size());
		if (c.size() == 3) begin
			rng("first slot", 10 * T, 30 * T, c[0]);
			chk("first kind", 1'h0, m[0]);
			rng("measured slot", 112 * T - 3, 112 * T + 3, c[1]);
			chk("measured kind", 1'h1, m[1]);
			chk("slot period", 100 * T, c[2] - c[1]);
		end
		$display("test schedule done");
	endtask
	// widths of both count pulses for one event of hi cycles
	task automatic t_pulse(input int hi, input int lo_en, input int hi_en);
		int nf;
		int ne;
		nf = 0;
		ne = 0;
		event_level = 1'h1;
		n_ev++;
		for (int k = 0; k < 1700; k++) begin
			cyc(1);
			if (k == hi - 1)
				event_level = 1'h0;
			nf += (fix_n === 1'h0);
			ne += (en_n === 1'h0);
		end
		chk("fixed width", dhs_pkg::FIX_CYC, nf);
		rng("energy width", lo_en, hi_en, ne);
		$display("test pulse %0d done", hi);
	endtask
	// burst inside one second raises the alarm, a quiet second drops it
	task automatic t_alarm;
		int k;
		chk("alarm idle", 1'h1, alarm_n);
		while (now % (10 * T) != 50)
			cyc(1);
		repeat (ACPS + 1) ev(20);
		k = 0;
		while (alarm_n !== 1'h0 && k < 600) begin
			cyc(1);
			k++;
		end
		chk("alarm raised", 1'h0, alarm_n);
		k = 0;
		while (alarm_n !== 1'h1 && k < 1200) begin
			cyc(1);
			k++;
		end
		rng("alarm hold", 10 * T - 2, 10 * T + 2, k);
		$display("test alarm done");
	endtask
	// one telecommand character, good or with a low stop bit
	task automatic t_cmd(input logic [7:0] d, input logic stop);
		logic       gv;
		logic       ge;
		logic [7:0] gd;
		gv = 1'h0;
		ge = 1'h0;
		gd = 8'h00;
		fork
			i_dhs_host_model.send(d, stop);
			for (int k = 0; k < 11 * dhs_pkg::BAUD_CYC; k++) begin
				cyc(1);
				if (cmd_valid === 1'h1)
					gd = cmd_data;
				gv |= (cmd_valid === 1'h1);
				ge |= (cmd_err === 1'h1);
			end
		join
		chk("cmd valid", stop, gv);
		chk("cmd frame error", !stop, ge);
		if (stop)
			chk("cmd data", d, gd);
		$display("test command %0h done", d);
	endtask
	// four bytes back to back into the two-entry buffer
	task automatic t_packet;
		logic [7:0] d[4] = '{8'hA5, 8'h3C, 8'h01, 8'hFF};
		logic       refused;
		int         k;
		refused = 1'h0;
		pkt_valid = 1'h1;
		for (int i = 0; i < 4; i++) begin
			pkt_data = d[i];
			pkt_last = (i == 3);
			for (k = 0; pkt_ready !== 1'h1 && k < 5000; k++) begin
				refused = 1'h1;
				cyc(1);
			end
			cyc(1);
		end
		pkt_valid = 1'h0;
		chk("buffer refused", 1'h1, refused);
		for (k = 0; strobe_n !== 1'h1 && k < 8000; k++)
			cyc(1);
		chk("strobe released", 1'h1, strobe_n);
		cyc(2);
		chk("bytes", 4, i_dhs_host_model.rx_q.size());
		for (int i = 0; i < i_dhs_host_model.rx_q.size() && i < 4; i++)
			chk("byte", d[i], i_dhs_host_model.rx_q[i]);
		chk("stop errors", 0, i_dhs_host_model.stop_errs);
		rng("lead ns", 80000, 350000, int'(i_dhs_host_model.lead_ns));
		rng("tail ns", 0, 350000, int'(i_dhs_host_model.tail_ns));
		chk("txd idle", 1'h1, txd);
		$display("test packet done");
	endtask
	// minute count, zero-count error and its release
	task automatic t_minute;
		chk("dose early", 1'h0, dose_valid);
		while (dose_valid !== 1'h1 && now < 600 * T + 10)
			cyc(1);
		rng("first dose", 600 * T - 3, 600 * T + 3, now);
		chk("minute count", n_ev, counts_per_minute);
		chk("error with counts", 1'h1, error_n);
		while (error_n !== 1'h0 && now < 1200 * T + 10)
			cyc(1);
		rng("zero count error", 1200 * T - 3, 1200 * T + 3, now);
		ev(20);
		chk("error released", 1'h1, error_n);
		$display("test minute done");
	endtask
	// main sequence
	initial begin
		rst_n = 1'h0;
		event_level = 1'h0;
		pkt_valid = 1'h0;
		pkt_data = 8'h00;
		pkt_last = 1'h0;
		n_errors = 0;
		cmp_count = 0;
		n_ev = 0;
		t_reset;
		t_sched;
		t_pulse(300, 298, 302);
		t_pulse(20, dhs_pkg::EN_MIN_CYC, dhs_pkg::EN_MIN_CYC + 2);
		t_pulse(1600, 1499, 1501);
		t_alarm;
		t_cmd(8'h5A, 1'h1);
		t_cmd(8'hC3, 1'h0);
		t_cmd(8'h81, 1'h1);
		t_packet;
		t_minute;
		t_reset;
		finish_test;
	end
	// watchdog: the whole run should take about 60000 cycles
	initial begin
		#(90000 * 100);
		n_errors++;
		$display("CHECK FAILED watchdog expected done seen timeout");
		finish_test;
	end
endmodule

// *** src/dhs_pkg.sv ***
// Notes on behaviour
// RULE1 - serial output sends 115200 baud, 8-N-1
// RULE2 - serial input receives 115200 baud, 8-N-1
// RULE3 - strobe low, first byte 80-350 us later
// RULE4 - strobe back high within 350 us
// RULE5 - measurement packet every 10 seconds
// RULE6 - all timing from one crystal timebase
// RULE7 - error low on zero or excess minute counts
// RULE8 - error judged per minute, released on count
// RULE9 - alarm low when one-second rate exceeds threshold
// RULE10 - alarm released next second below threshold
// RULE11 - fixed count pulse low 10-70 us
// RULE12 - energy pulse low 10-150 us, level driven
// RULE13 - reset input restarts the processing core
// RULE14 - initial packet 1 to 3 seconds after start
// RULE15 - first dose figure after a further minute
// RULE16 - reported dose clamps at full scale
// RULE17 - first measured packet about 11.2 s after start
// RULE18 - packets flow without any telecommand
// RULE19 - start bit low, LSB first, stop high, idle high
// RULE20 - strobe, error, alarm held high in reset
package dhs_pkg;
	// timebase and serial line
	localparam longint CLK_HZ        = 64'd10_000_000;  // core clock rate
	localparam int     CYC_PER_US    = int'(CLK_HZ / 64'd1_000_000);
	localparam int     BAUD          = 115200;
	localparam int     BAUD_CYC      = int'((CLK_HZ + 64'd57600) / 64'd115200);
	localparam int     HALF_BAUD     = BAUD_CYC / 2;
	localparam int     TICK_MS       = 100;             // schedule tick
	localparam int     TICK_CYC      = int'(CLK_HZ * 64'd100 / 64'd1000);
	// schedule in ticks
	localparam int     TICKS_PER_SEC = 10;
	localparam int     TICKS_PER_MIN = 600;
	localparam int     PKT_PERIOD    = 100;             // 10 s
	localparam int     INIT_PKT      = 20;              // 2 s
	localparam int     FIRST_MEAS    = 112;             // 11.2 s
	// strobe framing times
	localparam int     LEAD_US       = 200;
	localparam int     LEAD_MIN_US   = 80;
	localparam int     LEAD_MAX_US   = 350;
	localparam int     TAIL_US       = 50;
	localparam int     LEAD_CYC      = LEAD_US * CYC_PER_US;
	localparam int     LEAD_MIN_CYC  = LEAD_MIN_US * CYC_PER_US;
	localparam int     LEAD_MAX_CYC  = LEAD_MAX_US * CYC_PER_US;
	localparam int     TAIL_CYC      = TAIL_US * CYC_PER_US;
	// count pulses
	localparam int     FIX_US        = 50;
	localparam int     EN_MIN_US     = 10;
	localparam int     EN_MAX_US     = 150;
	localparam int     FIX_CYC       = FIX_US * CYC_PER_US;
	localparam int     EN_MIN_CYC    = EN_MIN_US * CYC_PER_US;
	localparam int     EN_MAX_CYC    = EN_MAX_US * CYC_PER_US;
	// count thresholds
	localparam int     ERR_CPM       = 900000;
	localparam int     ALARM_CPS     = 70;              // about 40 uSv/h

	// one buffered packet byte
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} dhs_byte_t;

	// strobe and transmit sequence, gray along the path
	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_LEAD = 2'h1,
		TX_SEND = 2'h3,
		TX_TAIL = 2'h2
	} dhs_tx_st_t;

	// whole block state
	typedef struct packed {
		dhs_tx_st_t      tx_st;
		logic [11:0]     wait_cnt;
		logic            busy;
		logic            last_sent;
		logic [6:0]      baud;
		logic [3:0]      bit_idx;
		logic [9:0]      shreg;
		logic            txd;
		logic            strobe_n;
		dhs_byte_t [1:0] buf_mem;
		logic            wr_ptr;
		logic            rd_ptr;
		logic [1:0]      buf_cnt;
		logic            pkt_ready;
		logic            rx_busy;
		logic [6:0]      rx_baud;
		logic [3:0]      rx_idx;
		logic [7:0]      rx_sh;
		logic            cmd_valid;
		logic            cmd_err;
		logic [7:0]      cmd_data;
		logic [19:0]     tick_cnt;
		logic [3:0]      sec_sub;
		logic [9:0]      min_sub;
		logic [6:0]      sched;
		logic            boot;
		logic            slot;
		logic            slot_meas;
		logic            ev_prev;
		logic [13:0]     sec_ev;
		logic [19:0]     min_ev;
		logic            alarm_n;
		logic            error_n;
		logic [9:0]      fix_cnt;
		logic            fix_n;
		logic [10:0]     en_cnt;
		logic            en_n;
		logic [19:0]     dose_cpm;
		logic            dose_valid;
	} dhs_state_t;

	localparam dhs_state_t ST_RST = '{tx_st: TX_IDLE, txd: 1'h1, strobe_n: 1'h1,
		pkt_ready: 1'h1, boot: 1'h1, alarm_n: 1'h1, error_n: 1'h1, fix_n: 1'h1,
		en_n: 1'h1, default: '0};
endpackage

// *** src/dhs_signals.sv ***
module dhs_signals #(
	parameter int TICK_CYC  = dhs_pkg::TICK_CYC,
	parameter int ALARM_CPS = dhs_pkg::ALARM_CPS
) (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// detector comparator level
	input  wire logic        EVENT_LEVEL,
	// packet bytes from the sentence builder
	input  wire logic        PKT_VALID,
	input  wire logic [7:0]  PKT_DATA,
	input  wire logic        PKT_LAST,
	output logic             PKT_READY,
	// packet schedule to the sentence builder
	output logic             SLOT,
	output logic             SLOT_MEAS,
	// host serial link
	output logic             TXD,
	input  wire logic        RXD,
	output logic             PACKET_STROBE_N,
	// received telecommand bytes
	output logic             CMD_VALID,
	output logic [7:0]       CMD_DATA,
	output logic             CMD_FRAME_ERR,
	// host flags and count pulses
	output logic             ERROR_N,
	output logic             ALARM_N,
	output logic             FIXED_COUNT_PULSE_N,
	output logic             ENERGY_COUNT_PULSE_N,
	// dose figure
	output logic [19:0]      COUNTS_PER_MINUTE,
	output logic             DOSE_VALID
);
	dhs_pkg::dhs_state_t q;        // registered state
	dhs_pkg::dhs_state_t d;        // next state
	logic                tick;     // 100 ms schedule tick
	logic                sec_end;  // last cycle of a second
	logic                min_end;  // last cycle of a minute
	logic                ev;       // new detector event
	logic                push;     // byte taken into buffer

	// refuse a tick too short or too long for the tick counter, or an alarm threshold the second count cannot hold
	if (TICK_CYC < 2 || TICK_CYC > 1048576 || ALARM_CPS < 1 || ALARM_CPS > 16383)
		$error("dhs_signals: parameter out of range");

	// single timebase drives every interval
	assign tick    = (q.tick_cnt == 20'(TICK_CYC - 1)); // RULE6
	assign sec_end = tick && (q.sec_sub == 4'(dhs_pkg::TICKS_PER_SEC - 1));
	assign min_end = tick && (q.min_sub == 10'(dhs_pkg::TICKS_PER_MIN - 1));
	assign ev      = EVENT_LEVEL && !q.ev_prev;
	assign push    = PKT_VALID && q.pkt_ready;

	// next-state logic for the whole block
	always_comb begin
		dhs_pkg::dhs_byte_t hd;
		logic               pop;
		d   = q;
		hd  = q.buf_mem[q.rd_ptr];
		pop = 1'h0;
		d.slot      = 1'h0;
		d.cmd_valid = 1'h0;
		d.cmd_err   = 1'h0;
		d.ev_prev   = EVENT_LEVEL;

		// timebase counters
		d.tick_cnt = tick ? 20'h00000 : 20'(q.tick_cnt + 20'h00001);
		if (tick) begin
			d.sec_sub = (q.sec_sub == 4'(dhs_pkg::TICKS_PER_SEC - 1)) ? 4'h0 :
				4'(q.sec_sub + 4'h1);
			d.min_sub = min_end ? 10'h000 : 10'(q.min_sub + 10'h001);
			// schedule runs on its own, the receiver never steers it
			// sched holds the ticks already gone, so a match fires on that tick itself
			if (q.sched == 7'(dhs_pkg::FIRST_MEAS - 1)) begin // RULE18
				d.slot      = 1'h1; // RULE17
				d.slot_meas = 1'h1;
				d.sched     = 7'(dhs_pkg::FIRST_MEAS - dhs_pkg::PKT_PERIOD); // RULE5
			end else begin
				d.sched = 7'(q.sched + 7'h01);
				if (q.boot && q.sched == 7'(dhs_pkg::INIT_PKT - 1)) begin // RULE14
					d.slot      = 1'h1;
					d.slot_meas = 1'h0;
					d.boot      = 1'h0;
				end
			end
		end

		// per-second count and alarm
		if (sec_end) begin
			d.alarm_n = !(q.sec_ev > 14'(ALARM_CPS)); // RULE9 RULE10
			d.sec_ev  = {13'h0000, ev};
		end else if (ev && q.sec_ev != 14'h3FFF) begin
			d.sec_ev = 14'(q.sec_ev + 14'h0001);
		end

		// per-minute count, error and dose; evaluation beats release
		if (min_end) begin
			if (q.min_ev == 20'h00000 || q.min_ev > 20'(dhs_pkg::ERR_CPM))
				d.error_n = 1'h0; // RULE7 RULE8
			d.dose_cpm = (q.min_ev > 20'(dhs_pkg::ERR_CPM)) ?
				20'(dhs_pkg::ERR_CPM) : q.min_ev; // RULE16
			d.dose_valid = 1'h1; // RULE15
			d.min_ev     = {19'h00000, ev};
		end else begin
			if (ev && !q.error_n)
				d.error_n = 1'h1; // RULE8
			if (ev && q.min_ev != 20'hFFFFF)
				d.min_ev = 20'(q.min_ev + 20'h00001);
		end

		// fixed-width pulse, a new event restarts it
		if (ev) begin
			d.fix_n   = 1'h0; // RULE11
			d.fix_cnt = 10'h000;
		end else if (!q.fix_n) begin
			if (q.fix_cnt == 10'(dhs_pkg::FIX_CYC - 1))
				d.fix_n = 1'h1;
			else
				d.fix_cnt = 10'(q.fix_cnt + 10'h001);
		end

		// energy pulse follows the level, clamped to its width window
		if (ev) begin
			d.en_n   = 1'h0; // RULE12
			d.en_cnt = 11'h000;
		end else if (!q.en_n) begin
			if ((q.en_cnt >= 11'(dhs_pkg::EN_MIN_CYC - 1) && !EVENT_LEVEL) ||
				q.en_cnt == 11'(dhs_pkg::EN_MAX_CYC - 1))
				d.en_n = 1'h1;
			else
				d.en_cnt = 11'(q.en_cnt + 11'h001);
		end

		// strobe and transmit sequence
		unique case (q.tx_st)
			dhs_pkg::TX_IDLE: begin
				// a waiting byte opens a packet
				if (q.buf_cnt != 2'h0) begin
					d.tx_st    = dhs_pkg::TX_LEAD;
					d.strobe_n = 1'h0; // RULE3
					d.wait_cnt = 12'h000;
				end
			end
			dhs_pkg::TX_LEAD: begin
				// hold the line idle so the host can wake first
				if (q.wait_cnt == 12'(dhs_pkg::LEAD_CYC - 1))
					pop = 1'h1; // RULE3
				else
					d.wait_cnt = 12'(q.wait_cnt + 12'h001);
			end
			dhs_pkg::TX_SEND: begin
				if (q.busy) begin
					if (q.baud == 7'(dhs_pkg::BAUD_CYC - 1)) begin // RULE1
						d.baud = 7'h00;
						if (q.bit_idx == 4'h9) begin
							d.busy = 1'h0;
						end else begin
							// next bit, stop bit fills from the top
							d.shreg   = {1'h1, q.shreg[9:1]};
							d.txd     = q.shreg[1]; // RULE19
							d.bit_idx = 4'(q.bit_idx + 4'h1);
						end
					end else begin
						d.baud = 7'(q.baud + 7'h01);
					end
				end else if (q.last_sent) begin
					d.tx_st    = dhs_pkg::TX_TAIL;
					d.wait_cnt = 12'h000;
				end else if (q.buf_cnt != 2'h0) begin
					pop = 1'h1;
				end
				// an empty buffer mid-packet leaves the line idle high
			end
			dhs_pkg::TX_TAIL: begin
				// short guard keeps the strobe around the final stop bit
				if (q.wait_cnt == 12'(dhs_pkg::TAIL_CYC - 1)) begin
					d.tx_st    = dhs_pkg::TX_IDLE;
					d.strobe_n = 1'h1; // RULE4
				end else begin
					d.wait_cnt = 12'(q.wait_cnt + 12'h001);
				end
			end
		endcase

		// load a byte: start bit low, data LSB first, stop high
		if (pop) begin
			d.tx_st     = dhs_pkg::TX_SEND;
			d.busy      = 1'h1;
			d.shreg     = {1'h1, hd.data, 1'h0}; // RULE19
			d.txd       = 1'h0;
			d.baud      = 7'h00;
			d.bit_idx   = 4'h0;
			d.last_sent = hd.last;
		end

		// two-entry buffer; ready drops only when both slots hold a byte
		if (push) begin
			d.buf_mem[q.wr_ptr] = {PKT_DATA, PKT_LAST};
			d.wr_ptr            = !q.wr_ptr;
		end
		if (pop)
			d.rd_ptr = !q.rd_ptr;
		d.buf_cnt   = 2'(q.buf_cnt + {1'h0, push} - {1'h0, pop});
		d.pkt_ready = (d.buf_cnt != 2'h2);

		// telecommand receiver, samples at mid-bit
		if (!q.rx_busy) begin
			if (!RXD) begin
				d.rx_busy = 1'h1;
				d.rx_baud = 7'(dhs_pkg::HALF_BAUD);
				d.rx_idx  = 4'h0;
			end
		end else if (q.rx_baud != 7'h00) begin
			d.rx_baud = 7'(q.rx_baud - 7'h01);
		end else begin
			d.rx_baud = 7'(dhs_pkg::BAUD_CYC - 1); // RULE2
			d.rx_idx  = 4'(q.rx_idx + 4'h1);
			if (q.rx_idx == 4'h0) begin
				// a glitch that is high again at mid start bit is dropped
				if (RXD)
					d.rx_busy = 1'h0;
			end else if (q.rx_idx < 4'h9) begin
				d.rx_sh = {RXD, q.rx_sh[7:1]}; // RULE19
			end else begin
				d.rx_busy   = 1'h0;
				d.cmd_data  = q.rx_sh;
				d.cmd_valid = RXD; // RULE2
				d.cmd_err   = !RXD;
			end
		end
	end

	// state register; reset restarts every part of the core
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			q <= dhs_pkg::ST_RST; // RULE13 RULE20
		else
			q <= d;
	end

	// outputs straight from state flip-flops
	assign PKT_READY            = q.pkt_ready;
	assign SLOT                 = q.slot;
	assign SLOT_MEAS            = q.slot_meas;
	assign TXD                  = q.txd;
	assign PACKET_STROBE_N      = q.strobe_n;
	assign CMD_VALID            = q.cmd_valid;
	assign CMD_DATA             = q.cmd_data;
	assign CMD_FRAME_ERR        = q.cmd_err;
	assign ERROR_N              = q.error_n;
	assign ALARM_N              = q.alarm_n;
	assign FIXED_COUNT_PULSE_N  = q.fix_n;
	assign ENERGY_COUNT_PULSE_N = q.en_n;
	assign COUNTS_PER_MINUTE    = q.dose_cpm;
	assign DOSE_VALID           = q.dose_valid;

	// checking helpers: ages of low outputs
	localparam int TAIL_BOUND = 600;
	logic [11:0] h_lead_age;   // cycles since strobe fell
	logic        h_lead_seen;  // first start bit seen
	logic [9:0]  h_fix_age;    // cycles fixed pulse low
	logic [10:0] h_en_age;     // cycles energy pulse low
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			h_lead_age  <= 12'h000;
			h_lead_seen <= 1'h0;
			h_fix_age   <= 10'h000;
			h_en_age    <= 11'h000;
		end else begin
			h_lead_age  <= PACKET_STROBE_N ? 12'h000 :
				((h_lead_age == 12'hFFF) ? h_lead_age : 12'(h_lead_age + 12'h001));
			h_lead_seen <= !PACKET_STROBE_N && (h_lead_seen || !TXD);
			h_fix_age   <= ev ? 10'h000 :
				(!FIXED_COUNT_PULSE_N ? 10'(h_fix_age + 10'h001) : h_fix_age);
			h_en_age    <= ev ? 11'h000 :
				(!ENERGY_COUNT_PULSE_N ? 11'(h_en_age + 11'h001) : h_en_age);
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	sequence s_first_start;
		!PACKET_STROBE_N && !h_lead_seen && $fell(TXD);
	endsequence
	sequence s_tail_entry;
		$rose(q.tx_st == dhs_pkg::TX_TAIL);
	endsequence

	AST_LEAD_TIME: assert property (s_first_start |-> // RULE3
		(h_lead_age >= 12'(dhs_pkg::LEAD_MIN_CYC) && h_lead_age <= 12'(dhs_pkg::LEAD_MAX_CYC)))
		else $error("first start bit outside strobe lead window");
	AST_TAIL_TIME: assert property (s_tail_entry |-> ##[1:TAIL_BOUND] PACKET_STROBE_N) // RULE4
		else $error("strobe not released after last byte");
	AST_START_BIT: assert property ($fell(TXD) |-> ##40 !TXD) // RULE19
		else $error("serial low level shorter than half a bit");
	AST_STOP_BIT: assert property ((q.busy && q.bit_idx == 4'h9) |-> TXD) // RULE1
		else $error("stop bit not high");
	AST_FIX_WIDTH: assert property ($rose(FIXED_COUNT_PULSE_N) |-> // RULE11
		h_fix_age == 10'(dhs_pkg::FIX_CYC))
		else $error("fixed pulse width wrong");
	AST_EN_WIDTH: assert property ($rose(ENERGY_COUNT_PULSE_N) |-> // RULE12
		(h_en_age >= 11'(dhs_pkg::EN_MIN_CYC) && h_en_age <= 11'(dhs_pkg::EN_MAX_CYC)))
		else $error("energy pulse width outside window");
	AST_ALARM_SET: assert property ((sec_end && q.sec_ev > 14'(ALARM_CPS)) |=> !ALARM_N) // RULE9
		else $error("alarm not raised");
	AST_ALARM_CLR: assert property ((sec_end && q.sec_ev <= 14'(ALARM_CPS)) |=> ALARM_N) // RULE10
		else $error("alarm not released");
	AST_ERR_SET: assert property ((min_end && q.min_ev == 20'h00000) |=> !ERROR_N) // RULE7
		else $error("error not raised on empty minute");
	AST_ERR_REL: assert property ((!ERROR_N && ev && !min_end) |=> ERROR_N) // RULE8
		else $error("error not released on count");
endmodule
